// >>> src/lgb_pkg.sv
package lgb_pkg;
  // ==========================================
  // register subaddresses
  localparam logic [7:0] LGB_GAMMA_BASE    = 8'h26;
  localparam logic [7:0] LGB_GAMMA_LAST    = 8'h33;
  localparam logic [7:0] LGB_AVG_LUMA_ADR  = 8'h34;
  localparam logic [7:0] LGB_CLKCTL_ADR    = 8'h35;
  localparam logic [7:0] LGB_MODE_ADR      = 8'h36;
  localparam int         LGB_NUM_POINTS    = 14;
  localparam int         LGB_CURVE_POINTS  = 7;
  // ==========================================
  // field positions and reset values
  localparam int         LGB_PLL_CLOCK_OUTPUT_PIN_EN_POS = 1;
  localparam int         LGB_GAMMA_EN_POS  = 0;
  localparam int         LGB_CURVE_SEL_POS = 1;
  localparam logic [7:0] LGB_CLKCTL_RST    = 8'h70;
  localparam logic [7:0] LGB_MODE_RST      = 8'h00;
  localparam logic [7:0] LGB_POINT_RST     = 8'h10;
  // ==========================================
  // fixed curve anchors
  localparam logic [7:0] LGB_FIX_LO        = 8'h10;
  localparam logic [7:0] LGB_FIX_HI        = 8'hf0;
  localparam logic [7:0] LGB_FIX_MAX       = 8'hff;
  // ==========================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lgb_reg_req_s;
  typedef struct packed {
    logic       active;
    logic       vsync_n;
    logic       is_luma;
    logic [7:0] data;
  } lgb_pix_s;
endpackage : lgb_pkg

// >>> src/lgb_gamma_map.sv
`timescale 1ns/100ps
`default_nettype none
module lgb_gamma_map
  import lgb_pkg::*;
(
  input  wire logic [7:0]  x_i,
  input  wire logic [55:0] pts_i,
  output logic      [7:0]  y_o
);
  // ==========================================
  // segment lookup and interpolation
  function automatic logic [7:0] pt(input logic [55:0] p, input int k);
    pt = p[k*8 +: 8];
  endfunction : pt

  logic [7:0]  x0, y0, y1, span;
  logic [15:0] prod;
  logic [8:0]  sum;

  // pick segment anchors
  always_comb
  begin
    x0   = 8'h00;
    y0   = 8'h00;
    y1   = LGB_FIX_LO;
    span = 8'h10;
    if (x_i < LGB_FIX_LO)
    begin
      x0 = 8'h00; y0 = 8'h00; y1 = LGB_FIX_LO; span = 8'h10;
    end
    else if (x_i < 8'h20)
    begin
      x0 = LGB_FIX_LO; y0 = LGB_FIX_LO; y1 = pt(pts_i, 0); span = 8'h10;
    end
    else if (x_i >= LGB_FIX_HI)
    begin
      x0 = LGB_FIX_HI; y0 = LGB_FIX_HI; y1 = LGB_FIX_MAX; span = 8'h0f;
    end
    else if (x_i >= 8'he0)
    begin
      x0 = 8'he0; y0 = pt(pts_i, 6); y1 = LGB_FIX_HI; span = 8'h10;
    end
    else
    begin
      x0 = {x_i[7:5], 5'h00};
      y0 = pt(pts_i, int'(x_i[7:5]) - 1);
      y1 = pt(pts_i, int'(x_i[7:5]));
      span = 8'h20;
    end
  end

  // linear interpolation between anchors, signed slope
  logic signed [9:0]  dy;
  logic signed [17:0] term;
  logic [7:0]         dx;
  always_comb
  begin
    dx   = x_i - x0;
    dy   = $signed({2'b00, y1}) - $signed({2'b00, y0});
    term = (dy * $signed({10'h000, dx})) / $signed({10'h000, span});
    prod = 16'(term);
    sum  = 9'({1'b0, y0} + prod[8:0]);
    y_o  = sum[7:0];
  end
endmodule : lgb_gamma_map
`default_nettype wire

// >>> src/lgb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lgb_top
  import lgb_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire lgb_reg_req_s reg_req_i,
  output logic      [7:0]   reg_rdata_o,
  input  wire lgb_pix_s     pix_i,
  output lgb_pix_s          pix_o,
  input  wire logic         pll_clk_i,
  input  wire logic         pll_control_bit_i,
  input  wire logic         oversample_enable_bit_i,
  output logic              pll_clock_output_pin_o
);
  // ==========================================
  // register file
  logic [7:0] points_reg [LGB_NUM_POINTS];
  logic [7:0] clkctl_reg;
  logic [7:0] mode_reg;
  logic [7:0] avg_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // gamma point storage
  genvar g;
  generate
    for (g = 0; g < LGB_NUM_POINTS; g++)
    begin : g_pt
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
          points_reg[g] <= LGB_POINT_RST;
        else if (reg_req_i.wr && hit(reg_req_i.addr, LGB_GAMMA_BASE + 8'(g)))
          points_reg[g] <= reg_req_i.wdata;
      end
    end
  endgenerate

  // clock output control register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      clkctl_reg <= LGB_CLKCTL_RST;
    else if (reg_req_i.wr && hit(reg_req_i.addr, LGB_CLKCTL_ADR))
      clkctl_reg <= reg_req_i.wdata;
  end

  // gamma mode register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      mode_reg <= LGB_MODE_RST;
    else if (reg_req_i.wr && hit(reg_req_i.addr, LGB_MODE_ADR))
      mode_reg <= reg_req_i.wdata;
  end

  // read mux; unmapped reads give zero, average is read-only
  always_comb
  begin
    reg_rdata_o = 8'h00;
    if (reg_req_i.addr >= LGB_GAMMA_BASE && reg_req_i.addr <= LGB_GAMMA_LAST)
      reg_rdata_o = points_reg[4'(reg_req_i.addr - LGB_GAMMA_BASE)];
    else if (hit(reg_req_i.addr, LGB_AVG_LUMA_ADR))
      reg_rdata_o = avg_reg;
    else if (hit(reg_req_i.addr, LGB_CLKCTL_ADR))
      reg_rdata_o = clkctl_reg;
    else if (hit(reg_req_i.addr, LGB_MODE_ADR))
      reg_rdata_o = mode_reg;
  end

  // ==========================================
  // gamma stage
  logic [55:0] curve_pts;
  logic [7:0]  mapped;
  always_comb
  begin
    curve_pts = '0;
    for (int k = 0; k < LGB_CURVE_POINTS; k++)
      curve_pts[k*8 +: 8] = mode_reg[LGB_CURVE_SEL_POS] ? points_reg[k + LGB_CURVE_POINTS]
                                                         : points_reg[k];
  end

  lgb_gamma_map u_map (
    .x_i   (pix_i.data),
    .pts_i (curve_pts),
    .y_o   (mapped)
  );

  // registered pixel output
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      pix_o <= '{active: 1'b0, vsync_n: 1'b1, is_luma: 1'b0, data: 8'h00};
    else
    begin
      pix_o <= pix_i;
      if (pix_i.is_luma && mode_reg[LGB_GAMMA_EN_POS])
        pix_o.data <= mapped;
    end
  end

  // ==========================================
  // brightness monitor
  logic [31:0] acc_reg;
  logic [23:0] cnt_reg;
  logic        vs_d_reg;
  logic        vs_fall;
  assign vs_fall = vs_d_reg && !pix_i.vsync_n;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      vs_d_reg <= 1'b1;
    else
      vs_d_reg <= pix_i.vsync_n;
  end

  // accumulate active luma per field
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || vs_fall)
    begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end
    else if (pix_i.active && pix_i.is_luma)
    begin
      acc_reg <= acc_reg + 32'(pix_i.data);
      cnt_reg <= cnt_reg + 24'h000001;
    end
  end

  // latch the field average
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      avg_reg <= 8'h00;
    else if (vs_fall)
      avg_reg <= (cnt_reg == 24'h0) ? 8'h00 : 8'(acc_reg / {8'h00, cnt_reg});
  end

  // ==========================================
  // clock output gate
  logic clk_gate;
  assign clk_gate = clkctl_reg[LGB_PLL_CLOCK_OUTPUT_PIN_EN_POS] && !pll_control_bit_i && oversample_enable_bit_i;
  assign pll_clock_output_pin_o = clk_gate & pll_clk_i;

  // ==========================================
  // checks
  // each antecedent except those of clk_gate_a and clk_on_a also asks for a sampled low reset: disable iff reads the
  // live reset, so the edge that applies a one-cycle reset would still start
  // an attempt whose next cycle sees the reset values

  // brightness register moves only on a vsync fall and ignores host writes
  avg_upd_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && !vs_fall)
    |=> $stable(avg_reg))
    else $error("average changed off vsync fall");
  avg_ro_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && reg_req_i.wr && hit(reg_req_i.addr, LGB_AVG_LUMA_ADR) && !vs_fall)
    |=> $stable(avg_reg))
    else $error("average register written");

  // chroma and bypassed luma leave the stage one cycle later unchanged
  chroma_pass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && !pix_i.is_luma)
    |=> pix_o.data == $past(pix_i.data))
    else $error("chroma altered");
  bypass_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && !mode_reg[LGB_GAMMA_EN_POS])
    |=> pix_o.data == $past(pix_i.data))
    else $error("bypass altered");

  // fixed anchors at 16 and 255 map to themselves
  anchor_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && pix_i.is_luma && mode_reg[LGB_GAMMA_EN_POS] && pix_i.data == LGB_FIX_LO)
    |=> pix_o.data == LGB_FIX_LO)
    else $error("fixed anchor moved");
  top_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && pix_i.is_luma && mode_reg[LGB_GAMMA_EN_POS] && pix_i.data == LGB_FIX_MAX)
    |=> pix_o.data == LGB_FIX_MAX)
    else $error("top anchor moved");

  // input 64 lands exactly on the second point of the selected curve
  point_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && pix_i.is_luma && mode_reg[LGB_GAMMA_EN_POS] && !mode_reg[LGB_CURVE_SEL_POS]
      && pix_i.data == 8'h40)
    |=> pix_o.data == $past(points_reg[1]))
    else $error("curve A point wrong");
  curve_b_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && pix_i.is_luma && mode_reg[LGB_GAMMA_EN_POS] && mode_reg[LGB_CURVE_SEL_POS]
      && pix_i.data == 8'h40)
    |=> pix_o.data == $past(points_reg[LGB_CURVE_POINTS + 1]))
    else $error("curve B point wrong");

  // a host write to the first point register lands on the next edge
  pt_wr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_i && reg_req_i.wr && hit(reg_req_i.addr, LGB_GAMMA_BASE))
    |=> points_reg[0] == $past(reg_req_i.wdata))
    else $error("point write lost");

  // clock pin is low unless enabled with pll and oversampling on, and follows the pll clock when enabled
  clk_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!clkctl_reg[LGB_PLL_CLOCK_OUTPUT_PIN_EN_POS] || pll_control_bit_i || !oversample_enable_bit_i)
    |-> !pll_clock_output_pin_o)
    else $error("clock out while pll off");
  clk_on_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (clkctl_reg[LGB_PLL_CLOCK_OUTPUT_PIN_EN_POS] && !pll_control_bit_i && oversample_enable_bit_i && pll_clk_i)
    |-> pll_clock_output_pin_o)
    else $error("clock out missing");
endmodule : lgb_top
`default_nettype wire

// >>> sim/lgb_pix_src.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// pixel source: one short field per go pulse
module lgb_pix_src
  import lgb_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [7:0] lvl_i,
  output logic            busy_o,
  output lgb_pix_s        pix_o
);
  logic [6:0] cnt_reg;

  // field position counter, wraps to idle after 127
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || go_i)
      cnt_reg <= {6'h00, go_i};
    else if (cnt_reg != 7'h00)
      cnt_reg <= cnt_reg + 7'h01;
  end

  // blanking, active luma and chroma, blanking, vsync low
  always_comb
  begin
    busy_o        = (cnt_reg != 7'h00);
    pix_o.active  = (cnt_reg >= 7'h10) && (cnt_reg < 7'h50);
    pix_o.is_luma = cnt_reg[0];
    pix_o.vsync_n = (cnt_reg < 7'h78);
    pix_o.data    = pix_o.active ? (cnt_reg[0] ? lvl_i : 8'hf0) : ~lvl_i;
  end
endmodule : lgb_pix_src
`default_nettype wire

// >>> sim/luma_gamma_brightness_pll_clock_output_pin_tb.sv
`timescale 1ns/100ps
`default_nettype none
module luma_gamma_brightness_pll_clock_output_pin_tb
  import lgb_pkg::*;
;
  typedef struct packed {logic [7:0] mode; logic lu; logic [7:0] x; logic [7:0] y;} lgb_row_s;
  // ==========================================
  // signals and tables
  logic         mclk_i       = 1'b0;
  logic         rst_i        = 1'b1;
  logic         pll_clk      = 1'b0;
  logic         pll_ctrl     = 1'b0;
  logic         os_en        = 1'b0;
  logic         go           = 1'b0;
  logic [7:0]   lvl          = 8'h00;
  logic         busy;
  logic         clk_pin;
  logic [7:0]   rdata;
  lgb_reg_req_s req          = '0;
  lgb_pix_s     tb_pix       = 11'h200;
  lgb_pix_s     src_pix;
  lgb_pix_s     pix_i;
  lgb_pix_s     pix_o;
  int           errors       = 0;
  int           total_checks = 0;
  logic [7:0]   pts [14]     = '{8'h4c, 8'h78, 8'h96, 8'hae, 8'hc4, 8'hd7, 8'he8,
                                 8'h20, 8'h50, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0};
  lgb_row_s     rows [18]    = '{
    '{8'h01, 1'b1, 8'h00, 8'h00}, '{8'h01, 1'b1, 8'h08, 8'h08}, '{8'h01, 1'b1, 8'h10, 8'h10},
    '{8'h01, 1'b1, 8'h18, 8'h2e}, '{8'h01, 1'b1, 8'h20, 8'h4c}, '{8'h01, 1'b1, 8'h30, 8'h62},
    '{8'h01, 1'b1, 8'h64, 8'h99}, '{8'h01, 1'b1, 8'hc8, 8'hdb}, '{8'h01, 1'b1, 8'he8, 8'hec},
    '{8'h01, 1'b1, 8'hf8, 8'hf8}, '{8'h01, 1'b1, 8'hff, 8'hff}, '{8'h03, 1'b1, 8'h64, 8'h64},
    '{8'h03, 1'b1, 8'hc8, 8'hc8}, '{8'h00, 1'b1, 8'h64, 8'h64}, '{8'h02, 1'b1, 8'h32, 8'h32},
    '{8'h01, 1'b0, 8'h30, 8'h30}, '{8'h01, 1'b1, 8'h40, 8'h78}, '{8'h03, 1'b1, 8'h40, 8'h50}};

  // clock and pixel source selection
  always #12.5 mclk_i = ~mclk_i;
  assign pix_i = busy ? src_pix : tb_pix;

  lgb_pix_src src_u (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .lvl_i(lvl), .busy_o(busy), .pix_o(src_pix));
  lgb_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata), .pix_i(pix_i),
    .pix_o(pix_o), .pll_clk_i(pll_clk), .pll_control_bit_i(pll_ctrl), .oversample_enable_bit_i(os_en),
    .pll_clock_output_pin_o(clk_pin));

  // ==========================================
  // tasks
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{1'b1, a, d};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    req.addr <= a;
    #1 chk("rdata", e, rdata);
  endtask : rd

  task automatic px(input logic lu, input logic [7:0] x, input logic [7:0] e);
    @(posedge mclk_i);
    tb_pix <= '{1'b1, 1'b1, lu, x};
    @(posedge mclk_i);
    #1 chk("pix", e, pix_o.data);
    chk("pix flags", {5'h00, 2'b11, lu}, {5'h00, pix_o.active, pix_o.vsync_n, pix_o.is_luma});
  endtask : px

  // one field; average holds the old value until the vsync fall
  task automatic field(input logic [7:0] l, input logic [7:0] o);
    int n;
    n = 0;
    @(posedge mclk_i);
    go <= 1'b1;
    lvl <= l;
    @(posedge mclk_i);
    go <= 1'b0;
    rd(LGB_AVG_LUMA_ADR, o);
    while (busy && n < 200)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 200)
    begin
      errors++;
      $display("ERROR field wait expected idle seen busy");
      test_done();
    end
    rd(LGB_AVG_LUMA_ADR, l);
  endtask : field

  // ==========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 14; i++)
      rd(LGB_GAMMA_BASE + 8'(i), LGB_POINT_RST);
    rd(LGB_CLKCTL_ADR, LGB_CLKCTL_RST);
    rd(LGB_MODE_ADR, LGB_MODE_RST);
    rd(LGB_AVG_LUMA_ADR, 8'h00);
    rd(8'h40, 8'h00);
    field(8'h64, 8'h00);
    wr(LGB_AVG_LUMA_ADR, 8'h00);
    rd(LGB_AVG_LUMA_ADR, 8'h64);
    field(8'h20, 8'h64);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(LGB_AVG_LUMA_ADR, 8'h00);
    for (int i = 0; i < 14; i++)
      wr(LGB_GAMMA_BASE + 8'(i), pts[i]);
    for (int i = 0; i < 14; i++)
      rd(LGB_GAMMA_BASE + 8'(i), pts[i]);
    foreach (rows[i])
    begin
      wr(LGB_MODE_ADR, rows[i].mode);
      px(rows[i].lu, rows[i].x, rows[i].y);
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(LGB_CLKCTL_ADR, {4'h7, 2'h0, i[0], 1'b0});
      @(posedge mclk_i);
      pll_ctrl <= i[1];
      os_en <= i[2];
      pll_clk <= i[3];
      #1 chk("pll_clock_output_pin", {7'h00, i[0] & !i[1] & i[2] & i[3]}, {7'h00, clk_pin});
    end
    test_done();
  end
endmodule : luma_gamma_brightness_pll_clock_output_pin_tb
`default_nettype wire
